// [verilog/ccs_pkg.sv]
// Purpose: Shared constants for the core special register block
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register index times four gives the byte address on the bus
package ccs_pkg;

  // ------------------------------------------------------------
  // Register indexes (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_STACK_POINTER = 8'h81;
  localparam logic [7:0] IDX_DATA_POINTER_LOW = 8'h82;
  localparam logic [7:0] IDX_DATA_POINTER_HIGH = 8'h83;
  localparam logic [7:0] IDX_PROGRAM_STATUS_WORD = 8'hd0;
  localparam logic [7:0] IDX_PRIMARY_OPERAND_REG = 8'he0;
  localparam logic [7:0] IDX_SECONDARY_OPERAND_REG = 8'hf0;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_DATA_POINTER_LOW = 8'h00;
  localparam logic [7:0] RST_DATA_POINTER_HIGH = 8'h00;
  localparam logic [7:0] RST_PROGRAM_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_PRIMARY_OPERAND_REG = 8'h00;
  localparam logic [7:0] RST_SECONDARY_OPERAND_REG = 8'h00;

  // ------------------------------------------------------------
  // Status word field positions
  // ------------------------------------------------------------
  localparam int POS_CARRY = 7;
  localparam int POS_HALF_CARRY = 6;
  localparam int POS_USER_ZERO = 5;
  localparam int POS_BANK_HI = 4;
  localparam int POS_BANK_LO = 3;
  localparam int POS_SIGNED_EXCESS = 2;
  localparam int POS_USER_ONE = 1;
  localparam int POS_PARITY = 0;

  // ------------------------------------------------------------
  // Working register area
  // ------------------------------------------------------------
  localparam int WREG_IDX_BITS = 3;
  localparam int BANK_BITS = 2;
  localparam logic [7:0] WREG_AREA_TOP = 8'h1f;

  // Stack pointer operation requested by the datapath
  typedef enum logic [1:0] {
    CCS_SP_HOLD,
    CCS_SP_PUSH,
    CCS_SP_POP,
    CCS_SP_LOAD
  } ccs_sp_op_t;

endpackage : ccs_pkg

// [verilog/ccs_byte_reg.sv]
// Purpose: One 8-bit architectural register with two write ports
// Assumes: Synchronous active-high reset, single clock
// Notes:   Software write port takes priority over the datapath port
module ccs_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Software write port
  input wire logic sw_we,
  input wire logic [7:0] sw_data,
  // Datapath write port
  input wire logic hw_we,
  input wire logic [7:0] hw_data,
  // Stored value
  output logic [7:0] q
);

  logic [7:0] val_ff;
  logic [7:0] nxt_val;

  // Bus write wins a collision: it is the later architectural intent
  assign nxt_val = sw_we ? sw_data : (hw_we ? hw_data : val_ff);
  assign q = val_ff;

  // Storage
  always_ff @(posedge clock) begin
    if (rst) begin
      val_ff <= RESET_VAL;
    end else begin
      val_ff <= nxt_val;
    end
  end

endmodule : ccs_byte_reg

// [verilog/ccs_addr_gen.sv]
// Purpose: Registered address outputs derived from the core registers
// Assumes: Inputs are flip-flop outputs on the same clock
// Notes:   Every address lags the registers that feed it by one cycle
module ccs_addr_gen (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register values
  input wire logic [1:0] bank_sel,
  input wire logic [2:0] wreg_idx,
  input wire logic [7:0] sp,
  input wire logic [15:0] data_pointer,
  input wire logic [7:0] acc,
  // Addresses
  output logic [7:0] wreg_addr,
  output logic [7:0] push_addr,
  output logic [15:0] xdata_addr,
  output logic [15:0] table_addr
);

  logic [7:0] nxt_wreg;
  logic [7:0] nxt_push;
  logic [15:0] nxt_table;
  logic [7:0] wreg_ff;
  logic [7:0] push_ff;
  logic [15:0] xdata_ff;
  logic [15:0] table_ff;

  // bank to RAM
  // Bank select forms bits 4:3, so banks sit 8 bytes apart
  // area 00h-1Fh
  assign nxt_wreg = {3'b000, bank_sel, wreg_idx};
  assign nxt_push = sp + 8'h01;
  // table address
  // Table reads wrap modulo 64K, as the datapath adder would
  assign nxt_table = data_pointer + {8'h00, acc};

  always_ff @(posedge clock) begin
    if (rst) begin
      wreg_ff <= 8'h00;
      push_ff <= 8'h00;
      xdata_ff <= 16'h0000;
      table_ff <= 16'h0000;
    end else begin
      wreg_ff <= nxt_wreg;
      push_ff <= nxt_push;
      xdata_ff <= data_pointer;
      table_ff <= nxt_table;
    end
  end

  assign wreg_addr = wreg_ff;
  assign push_addr = push_ff;
  assign xdata_addr = xdata_ff;
  assign table_addr = table_ff;

endmodule : ccs_addr_gen

// [verilog/ccs_core_regs.sv]
// Purpose: Architectural core registers of an 8-bit controller core
// Assumes: Software reaches the registers over APB, datapath by strobes
// Notes:   Zero-wait APB slave; bus writes win over datapath updates
//
// The APB register port was chosen for this implementation.
module ccs_core_regs #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Datapath: operand register loads
  input wire logic ACC_LOAD,
  input wire logic [7:0] ACC_DATA,
  input wire logic B_LOAD,
  input wire logic [7:0] B_DATA,
  // Datapath: arithmetic flag updates
  input wire logic CARRY_LOAD,
  input wire logic CARRY_DATA,
  input wire logic HALF_CARRY_LOAD,
  input wire logic HALF_CARRY_DATA,
  input wire logic EXCESS_LOAD,
  input wire logic EXCESS_DATA,
  // Datapath: stack pointer
  input wire ccs_pkg::ccs_sp_op_t SP_OP,
  input wire logic [7:0] SP_DATA,
  // Datapath: data pointer
  input wire logic DATA_POINTER_LOAD,
  input wire logic [15:0] DATA_POINTER_DATA,
  input wire logic DATA_POINTER_INC,
  // Datapath: working register select
  input wire logic [2:0] WREG_IDX,
  // Register values
  output logic [7:0] ACC_Q,
  output logic [7:0] B_Q,
  output logic [7:0] PSW_Q,
  output logic [7:0] SP_Q,
  output logic [15:0] DATA_POINTER_Q,
  // Derived addresses
  output logic [7:0] WREG_ADDR,
  output logic [7:0] PUSH_ADDR,
  output logic [15:0] XDATA_ADDR,
  output logic [15:0] TABLE_ADDR
);

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic [ADDR_W-3:0] word_idx;
  logic aligned;
  logic hit_sp;
  logic hit_dpl;
  logic hit_dph;
  logic hit_psw;
  logic hit_acc;
  logic hit_b;
  logic mapped;
  logic access;
  logic setup;
  logic wr_ok;

  assign word_idx = PADDR[ADDR_W-1:2];
  assign aligned = (PADDR[1:0] == 2'b00);

  // Index compare; upper address bits must be zero
  assign hit_sp = aligned && (word_idx == (ADDR_W-2)'(ccs_pkg::IDX_STACK_POINTER));
  assign hit_dpl = aligned && (word_idx == (ADDR_W-2)'(ccs_pkg::IDX_DATA_POINTER_LOW));
  assign hit_dph = aligned && (word_idx == (ADDR_W-2)'(ccs_pkg::IDX_DATA_POINTER_HIGH));
  assign hit_psw = aligned && (word_idx == (ADDR_W-2)'(ccs_pkg::IDX_PROGRAM_STATUS_WORD));
  assign hit_acc = aligned && (word_idx == (ADDR_W-2)'(ccs_pkg::IDX_PRIMARY_OPERAND_REG));
  assign hit_b = aligned && (word_idx == (ADDR_W-2)'(ccs_pkg::IDX_SECONDARY_OPERAND_REG));
  assign mapped = hit_sp | hit_dpl | hit_dph | hit_psw | hit_acc | hit_b;

  // Zero-wait slave: every access phase completes in its first cycle
  assign setup = PSEL && !PENABLE;
  assign access = PSEL && PENABLE;
  assign wr_ok = access && PWRITE && mapped;
  assign PREADY = 1'b1;
  assign PSLVERR = access && !mapped;

  // Per-register software write strobes
  logic sw_sp;
  logic sw_dpl;
  logic sw_dph;
  logic sw_psw;
  logic sw_acc;
  logic sw_b;
  logic [7:0] sw_byte;

  assign sw_sp = wr_ok && hit_sp;
  assign sw_dpl = wr_ok && hit_dpl;
  assign sw_dph = wr_ok && hit_dph;
  assign sw_psw = wr_ok && hit_psw;
  assign sw_acc = wr_ok && hit_acc;
  assign sw_b = wr_ok && hit_b;
  assign sw_byte = PWDATA[7:0];

  // ------------------------------------------------------------
  // Operand registers
  // ------------------------------------------------------------
  logic [7:0] acc_q;
  logic [7:0] b_q;

  ccs_byte_reg #(
    .RESET_VAL(ccs_pkg::RST_PRIMARY_OPERAND_REG)
  ) u_acc (
    .clock(CLOCK),
    .rst(RST),
    .sw_we(sw_acc),
    .sw_data(sw_byte),
    .hw_we(ACC_LOAD),
    .hw_data(ACC_DATA),
    .q(acc_q)
  );

  ccs_byte_reg #(
    .RESET_VAL(ccs_pkg::RST_SECONDARY_OPERAND_REG)
  ) u_b (
    .clock(CLOCK),
    .rst(RST),
    .sw_we(sw_b),
    .sw_data(sw_byte),
    .hw_we(B_LOAD),
    .hw_data(B_DATA),
    .q(b_q)
  );

  // ------------------------------------------------------------
  // Stack pointer
  // ------------------------------------------------------------
  logic [7:0] sp_q;
  logic sp_hw_we;
  logic [7:0] sp_hw_data;

  // increment on push
  // Push bumps the pointer first so the stored byte lands at sp+1;
  // pop reads at sp and then steps back. Both wrap modulo 256.
  assign sp_hw_we = (SP_OP != ccs_pkg::CCS_SP_HOLD);
  assign sp_hw_data = (SP_OP == ccs_pkg::CCS_SP_PUSH) ? sp_q + 8'h01 :
                      (SP_OP == ccs_pkg::CCS_SP_POP) ? sp_q - 8'h01 : SP_DATA;

  ccs_byte_reg #(
    .RESET_VAL(ccs_pkg::RST_STACK_POINTER)
  ) u_sp (
    .clock(CLOCK),
    .rst(RST),
    .sw_we(sw_sp),
    .sw_data(sw_byte),
    .hw_we(sp_hw_we),
    .hw_data(sp_hw_data),
    .q(sp_q)
  );

  // ------------------------------------------------------------
  // Data pointer
  // ------------------------------------------------------------
  logic [7:0] dpl_q;
  logic [7:0] dph_q;
  logic dp_hw_we;
  logic [15:0] dp_hw_data;

  // 16-bit load or step
  // A full load beats an increment issued in the same cycle
  assign dp_hw_we = DATA_POINTER_LOAD || DATA_POINTER_INC;
  assign dp_hw_data = DATA_POINTER_LOAD ? DATA_POINTER_DATA : {dph_q, dpl_q} + 16'h0001;

  ccs_byte_reg #(
    .RESET_VAL(ccs_pkg::RST_DATA_POINTER_LOW)
  ) u_dpl (
    .clock(CLOCK),
    .rst(RST),
    .sw_we(sw_dpl),
    .sw_data(sw_byte),
    .hw_we(dp_hw_we),
    .hw_data(dp_hw_data[7:0]),
    .q(dpl_q)
  );

  ccs_byte_reg #(
    .RESET_VAL(ccs_pkg::RST_DATA_POINTER_HIGH)
  ) u_dph (
    .clock(CLOCK),
    .rst(RST),
    .sw_we(sw_dph),
    .sw_data(sw_byte),
    .hw_we(dp_hw_we),
    .hw_data(dp_hw_data[15:8]),
    .q(dph_q)
  );

  // ------------------------------------------------------------
  // Program status word
  // ------------------------------------------------------------
  logic carry_ff;
  logic half_carry_ff;
  logic user_zero_ff;
  logic [1:0] bank_ff;
  logic excess_ff;
  logic user_one_ff;
  logic parity_ff;
  logic nxt_carry;
  logic nxt_half_carry;
  logic nxt_excess;
  logic nxt_user_zero;
  logic nxt_user_one;
  logic [1:0] nxt_bank;
  logic [7:0] nxt_acc;
  logic nxt_parity;

  // arithmetic flags
  // Bus writes to the status word or datapath strobes update the flags; otherwise they hold
  assign nxt_carry = sw_psw ? sw_byte[ccs_pkg::POS_CARRY] :
                     (CARRY_LOAD ? CARRY_DATA : carry_ff);
  assign nxt_half_carry = sw_psw ? sw_byte[ccs_pkg::POS_HALF_CARRY] :
                          (HALF_CARRY_LOAD ? HALF_CARRY_DATA : half_carry_ff);
  assign nxt_excess = sw_psw ? sw_byte[ccs_pkg::POS_SIGNED_EXCESS] :
                      (EXCESS_LOAD ? EXCESS_DATA : excess_ff);

  assign nxt_user_zero = sw_psw ? sw_byte[ccs_pkg::POS_USER_ZERO] : user_zero_ff;
  assign nxt_user_one = sw_psw ? sw_byte[ccs_pkg::POS_USER_ONE] : user_one_ff;
  assign nxt_bank = sw_psw ? sw_byte[ccs_pkg::POS_BANK_HI:ccs_pkg::POS_BANK_LO] : bank_ff;

  // even parity tracking
  // Parity follows the next operand value so it never lags the register;
  // a software write to its bit is ignored.
  assign nxt_acc = sw_acc ? sw_byte : (ACC_LOAD ? ACC_DATA : acc_q);
  assign nxt_parity = ^nxt_acc;

  // Status word storage
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      carry_ff <= ccs_pkg::RST_PROGRAM_STATUS_WORD[ccs_pkg::POS_CARRY];
      half_carry_ff <= ccs_pkg::RST_PROGRAM_STATUS_WORD[ccs_pkg::POS_HALF_CARRY];
      user_zero_ff <= ccs_pkg::RST_PROGRAM_STATUS_WORD[ccs_pkg::POS_USER_ZERO];
      bank_ff <= ccs_pkg::RST_PROGRAM_STATUS_WORD[ccs_pkg::POS_BANK_HI:ccs_pkg::POS_BANK_LO];
      excess_ff <= ccs_pkg::RST_PROGRAM_STATUS_WORD[ccs_pkg::POS_SIGNED_EXCESS];
      user_one_ff <= ccs_pkg::RST_PROGRAM_STATUS_WORD[ccs_pkg::POS_USER_ONE];
      parity_ff <= ccs_pkg::RST_PROGRAM_STATUS_WORD[ccs_pkg::POS_PARITY];
    end else begin
      carry_ff <= nxt_carry;
      half_carry_ff <= nxt_half_carry;
      user_zero_ff <= nxt_user_zero;
      bank_ff <= nxt_bank;
      excess_ff <= nxt_excess;
      user_one_ff <= nxt_user_one;
      parity_ff <= nxt_parity;
    end
  end

  logic [7:0] psw_q;
  assign psw_q = {carry_ff, half_carry_ff, user_zero_ff, bank_ff,
                  excess_ff, user_one_ff, parity_ff};

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;

  // Unmapped reads return zero alongside the error response
  assign rd_byte = hit_sp ? sp_q :
                   hit_dpl ? dpl_q :
                   hit_dph ? dph_q :
                   hit_psw ? psw_q :
                   hit_acc ? acc_q :
                   hit_b ? b_q : 8'h00;
  assign nxt_prdata = (setup && !PWRITE) ? {24'h000000, rd_byte} : prdata_ff;

  // Capture in the setup cycle so data are steady for the access phase
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      prdata_ff <= 32'h00000000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign PRDATA = prdata_ff;

  // ------------------------------------------------------------
  // Derived addresses
  // ------------------------------------------------------------
  // external and table addresses
  ccs_addr_gen u_addr (
    .clock(CLOCK),
    .rst(RST),
    .bank_sel(bank_ff),
    .wreg_idx(WREG_IDX),
    .sp(sp_q),
    .data_pointer({dph_q, dpl_q}),
    .acc(acc_q),
    .wreg_addr(WREG_ADDR),
    .push_addr(PUSH_ADDR),
    .xdata_addr(XDATA_ADDR),
    .table_addr(TABLE_ADDR)
  );

  // Register values to the datapath
  assign ACC_Q = acc_q;
  assign B_Q = b_q;
  assign PSW_Q = psw_q;
  assign SP_Q = sp_q;
  assign DATA_POINTER_Q = {dph_q, dpl_q};

endmodule : ccs_core_regs

// [bench/ccs_core_regs_checker.sv]
// Purpose: Port assertions for the core register block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bus writes win, so datapath checks skip those cycles
module ccs_core_regs_checker #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Bus
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PSLVERR,
  // Datapath strobes
  input wire logic ACC_LOAD,
  input wire logic [7:0] ACC_DATA,
  input wire logic CARRY_LOAD,
  input wire logic HALF_CARRY_LOAD,
  input wire logic EXCESS_LOAD,
  input wire ccs_pkg::ccs_sp_op_t SP_OP,
  input wire logic DATA_POINTER_LOAD,
  input wire logic [15:0] DATA_POINTER_DATA,
  input wire logic [2:0] WREG_IDX,
  // Values and addresses
  input wire logic [7:0] ACC_Q,
  input wire logic [7:0] PSW_Q,
  input wire logic [7:0] SP_Q,
  input wire logic [15:0] DATA_POINTER_Q,
  input wire logic [7:0] WREG_ADDR,
  input wire logic [7:0] PUSH_ADDR,
  input wire logic [15:0] XDATA_ADDR,
  input wire logic [15:0] TABLE_ADDR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  // Bus write decode; byte address is index times four
  wire logic wr = PSEL && PENABLE && PWRITE;
  wire logic wr_acc = wr && PADDR == 12'h380;
  wire logic wr_psw = wr && PADDR == 12'h340;
  wire logic wr_sp = wr && PADDR == 12'h204;
  wire logic wr_dp = wr && (PADDR == 12'h208 || PADDR == 12'h20c);
  wire logic ok_adr = PADDR inside {12'h204, 12'h208, 12'h20c, 12'h340, 12'h380, 12'h3c0};
  // Status word slices, so the sampled functions see plain signals
  wire logic [1:0] bank = PSW_Q[4:3];
  wire logic [3:0] usr = {PSW_Q[5:3], PSW_Q[1]};
  wire logic [2:0] ari = {PSW_Q[7:6], PSW_Q[2]};
  sequence s_sp_wr;
    PSEL && !PENABLE && PWRITE && PADDR == 12'h204 ##1 PSEL && PENABLE;
  endsequence
  chk_sp_bus: assert property (s_sp_wr |=> SP_Q == 8'($past(PWDATA)))
    else $error("stack pointer lost a write");
  chk_parity_even: assert property (PSW_Q[0] == ^ACC_Q)
    else $error("parity bit wrong");
  chk_acc_load: assert property (ACC_LOAD && !wr_acc |=> ACC_Q == $past(ACC_DATA))
    else $error("operand load lost");
  chk_sp_push: assert property (SP_OP == ccs_pkg::CCS_SP_PUSH && !wr_sp
    |=> SP_Q == $past(SP_Q) + 8'h01)
    else $error("push did not step");
  chk_push_target: assert property (!$past(RST) |-> PUSH_ADDR == $past(SP_Q) + 8'h01)
    else $error("push target wrong");
  chk_bank_map: assert property (!$past(RST)
    |-> WREG_ADDR == {3'b000, $past(bank), $past(WREG_IDX)})
    else $error("bank address wrong");
  chk_ptr_addr: assert property (!$past(RST)
    |-> XDATA_ADDR == $past(DATA_POINTER_Q) && TABLE_ADDR == $past(DATA_POINTER_Q) + 16'($past(ACC_Q)))
    else $error("pointer address wrong");
  chk_user_hold: assert property (!wr_psw |=> $stable(usr))
    else $error("user bits moved");
  chk_arith_hold: assert property (!(CARRY_LOAD || HALF_CARRY_LOAD || EXCESS_LOAD || wr_psw)
    |=> $stable(ari))
    else $error("flag moved");
  chk_data_pointer_load: assert property (DATA_POINTER_LOAD && !wr_dp |=> DATA_POINTER_Q == $past(DATA_POINTER_DATA))
    else $error("pointer load lost");
  chk_bad_addr: assert property (PSEL && PENABLE |-> PSLVERR == !ok_adr)
    else $error("error flag wrong");
endmodule : ccs_core_regs_checker

bind ccs_core_regs ccs_core_regs_checker #(.ADDR_W(ADDR_W)) ccs_core_regs_checker_inst (.*);

// [bench/ccs_dp_model.sv]
// Purpose: Datapath partner driving the register strobes
// Assumes: Drives by non-blocking assignment after a rising edge
// Notes:   One strobe per call, one cycle long
module ccs_dp_model (
  // Clock
  input wire logic clock,
  // Loads
  output logic acc_load,
  output logic [7:0] acc_data,
  output logic b_load,
  output logic [7:0] b_data,
  output logic cy_load,
  output logic cy_data,
  output logic hc_load,
  output logic hc_data,
  output logic ex_load,
  output logic ex_data,
  // Pointers
  output ccs_pkg::ccs_sp_op_t sp_op,
  output logic [7:0] sp_data,
  output logic data_pointer_load,
  output logic [15:0] data_pointer_data,
  output logic data_pointer_inc,
  output logic [2:0] wreg_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle from time zero
  initial begin
    {acc_load, b_load, cy_load, hc_load, ex_load, data_pointer_load, data_pointer_inc} = 7'h00;
    {acc_data, b_data, sp_data, data_pointer_data, cy_data, hc_data, ex_data} = 43'h0;
    sp_op = ccs_pkg::CCS_SP_HOLD;
    wreg_idx = 3'h0;
  end
  // Kind 0 operand, 1 second, 2-4 flags, 5 stack op d[9:8], 6 load, 7 step, 8 reg
  task automatic step(input int k, input logic [15:0] d);
    @(posedge clock);
    {acc_load, b_load, cy_load, hc_load, ex_load} <= {k == 0, k == 1, k == 2, k == 3, k == 4};
    {data_pointer_load, data_pointer_inc} <= {k == 6, k == 7};
    sp_op <= k == 5 ? ccs_pkg::ccs_sp_op_t'(d[9:8]) : ccs_pkg::CCS_SP_HOLD;
    {acc_data, b_data, sp_data, data_pointer_data} <= {d[7:0], d[7:0], d[7:0], d};
    {cy_data, hc_data, ex_data} <= {3{d[0]}};
    if (k == 8) wreg_idx <= d[2:0];
    @(posedge clock);
    // Stale data inverted so an unqualified capture cannot pass by luck
    {acc_load, b_load, cy_load, hc_load, ex_load, data_pointer_load, data_pointer_inc} <= 7'h00;
    sp_op <= ccs_pkg::CCS_SP_HOLD;
    {acc_data, b_data, sp_data, data_pointer_data} <= ~{d[7:0], d[7:0], d[7:0], d};
    {cy_data, hc_data, ex_data} <= ~{3{d[0]}};
  endtask : step
endmodule : ccs_dp_model

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the core register block
// Assumes: Bus slave answers when it likes; partner drives datapath
// Notes:   Run is about 140 cycles
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Bench signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, acc_load, b_load, cy_load, cy_data, hc_load, hc_data;
  logic ex_load, ex_data, data_pointer_load, data_pointer_inc;
  logic [7:0] acc_data, b_data, sp_data, acc_q, b_q, psw_q, sp_q, wreg_addr, push_addr;
  logic [15:0] data_pointer_data, data_pointer_q, xdata_addr, table_addr;
  logic [2:0] wreg_idx;
  ccs_pkg::ccs_sp_op_t sp_op;
  int miscompares = 0;
  int check_count = 0;
  // Byte addresses, reset values, patterns, stack results
  logic [11:0] adr [6] = '{12'h204, 12'h208, 12'h20c, 12'h340, 12'h380, 12'h3c0};
  logic [7:0] rsv [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] val [6] = '{8'h5a, 8'h34, 8'h12, 8'hfe, 8'h97, 8'hc3};
  logic [7:0] spx [4] = '{8'hff, 8'h00, 8'hff, 8'h30};

  ccs_core_regs #(.ADDR_W(12)) ccs_core_regs_inst (
    .CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .ACC_LOAD(acc_load), .ACC_DATA(acc_data), .B_LOAD(b_load), .B_DATA(b_data),
    .CARRY_LOAD(cy_load), .CARRY_DATA(cy_data), .HALF_CARRY_LOAD(hc_load),
    .HALF_CARRY_DATA(hc_data), .EXCESS_LOAD(ex_load), .EXCESS_DATA(ex_data),
    .SP_OP(sp_op), .SP_DATA(sp_data), .DATA_POINTER_LOAD(data_pointer_load), .DATA_POINTER_DATA(data_pointer_data),
    .DATA_POINTER_INC(data_pointer_inc), .WREG_IDX(wreg_idx), .ACC_Q(acc_q), .B_Q(b_q), .PSW_Q(psw_q),
    .SP_Q(sp_q), .DATA_POINTER_Q(data_pointer_q), .WREG_ADDR(wreg_addr), .PUSH_ADDR(push_addr),
    .XDATA_ADDR(xdata_addr), .TABLE_ADDR(table_addr)
  );
  ccs_dp_model ccs_dp_model_inst (.clock(clk), .*);

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // Bus cycle; only the watchdog ends a wait for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, adr[i], 8'h00);
      chk(rd, {24'h000000, rsv[i]});
    end
    chk(32'(push_addr), 32'h08);
  endtask : t_reset

  // Write all, read all; status bit 0 follows the operand; bad places refused
  task automatic t_regs();
    for (int i = 0; i < 6; i++) apb(1'b1, adr[i], val[i]);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, adr[i], 8'h00);
      chk(rd, {24'h0, i == 3 ? {val[3][7:1], ^val[4]} : val[i]});
    end
    apb(1'b1, 12'h3c4, 8'h00);
    chk(32'(er), 32'h1);
    apb(1'b0, 12'h3c0, 8'h00);
    chk(rd, 32'hc3);
    apb(1'b0, 12'h205, 8'h00);
    // Error flag and zero data are separate compares so neither is cut away
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
  endtask : t_regs

  // Arithmetic flags move, user bits stay; bank maps the working registers
  task automatic t_flags();
    for (int k = 2; k < 5; k++) ccs_dp_model_inst.step(k, 16'h0000);
    ccs_dp_model_inst.step(0, 16'h0001);
    ccs_dp_model_inst.step(2, 16'h0001);
    #1;
    chk(32'(psw_q), 32'hbb);
    chk(32'(acc_q), 32'h01);
    ccs_dp_model_inst.step(8, 16'h0005);
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, 12'h340, {3'b001, 2'(b), 3'b000});
      @(posedge clk);
      #1;
      chk(32'(wreg_addr), {27'h0, 2'(b), 3'h5});
    end
  endtask : t_flags

  // Every stack operation from the wrap point
  task automatic t_stack();
    apb(1'b1, 12'h204, 8'hff);
    for (int o = 0; o < 4; o++) begin
      ccs_dp_model_inst.step(5, {6'h00, 2'(o), 8'h30});
      #1;
      chk(32'(sp_q), 32'(spx[o]));
      @(posedge clk);
      #1;
      chk(32'(push_addr), 32'(8'(spx[o] + 8'h01)));
    end
  endtask : t_stack

  // Pointer load, step, byte write; table address wraps
  task automatic t_data_pointer();
    ccs_dp_model_inst.step(1, 16'h00a5);
    ccs_dp_model_inst.step(0, 16'h0020);
    ccs_dp_model_inst.step(6, 16'hfff0);
    #1;
    chk(32'(b_q), 32'ha5);
    chk(32'(data_pointer_q), 32'hfff0);
    ccs_dp_model_inst.step(7, 16'h0000);
    @(posedge clk);
    #1;
    chk({xdata_addr, table_addr}, 32'hfff10011);
    apb(1'b1, 12'h20c, 8'h12);
    apb(1'b0, 12'h208, 8'h00);
    chk(rd, 32'hf1);
    chk(32'(data_pointer_q), 32'h12f1);
  endtask : t_data_pointer

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_flags();
    t_stack();
    t_data_pointer();
    stop_test();
  end

  // Watchdog, some 36 times the expected run
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
endmodule : tb_top
